// ---- frb_pkg.sv ----
`default_nettype none
package frb_pkg;
   // ----------------------------------------------------------------
   // record layout, byte numbers within the block read
   // ----------------------------------------------------------------
   localparam logic [7:0] REC_LEN      = 8'h93;  // full log length
   localparam logic [7:0] OFS_TIME     = 8'h05;  // timestamp, low byte first
   localparam logic [7:0] OFS_VOUT_PK  = 8'h0B;  // ch0 then ch1
   localparam logic [7:0] OFS_IOUT_PK  = 8'h0F;
   localparam logic [7:0] OFS_VIN_PK   = 8'h13;
   localparam logic [7:0] OFS_TEMP     = 8'h15;  // ext0, ext1, die
   localparam logic [7:0] OFS_EVENT    = 8'h1B;  // newest event page
   localparam logic [7:0] OFS_STATUS   = 8'h27;  // status bytes of event n
   localparam logic [7:0] OFS_LAST     = 8'h2E;  // last byte built here
   localparam int         IMG_BYTES    = 47;
   localparam int         IMG_W        = IMG_BYTES * 8;
   localparam int         TS_W         = 48;

   // ----------------------------------------------------------------
   // measurement selector codes of the converter sweep
   // ----------------------------------------------------------------
   localparam logic [3:0] SEL_VOUT0    = 4'h0;
   localparam logic [3:0] SEL_VOUT1    = 4'h1;
   localparam logic [3:0] SEL_IOUT0    = 4'h2;
   localparam logic [3:0] SEL_IOUT1    = 4'h3;
   localparam logic [3:0] SEL_VIN      = 4'h4;
   localparam logic [3:0] SEL_IIN      = 4'h5;
   localparam logic [3:0] SEL_TEXT0    = 4'h6;
   localparam logic [3:0] SEL_TEXT1    = 4'h7;
   localparam logic [3:0] SEL_TDIE     = 4'h8;
   localparam int         SEL_COUNT    = 9;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int         CLK_NS       = 100;
   localparam int         TICK_NS      = 200000;  // timestamp resolution
   localparam int         TICK_CYCLES  = (TICK_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [10:0] TICK_LAST   = 11'(TICK_CYCLES - 1);

   typedef enum {
      FRB_IDLE,
      FRB_PENDING,
      FRB_LOGGED
   } frb_state_t;
endpackage
`default_nettype wire

// ---- frb_record_builder.sv ----
`default_nettype none
module frb_record_builder
   import frb_pkg::*;
(
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        rst_n_in,
   // converter sweep readings
   input  wire logic        meas_valid_in,
   input  wire logic [3:0]  meas_sel_in,
   input  wire logic [15:0] meas_data_in,
   input  wire logic        sweep_done_in,
   // status levels, sampled when the record is committed
   input  wire logic [7:0]  status_vout0_in,
   input  wire logic [7:0]  status_vout1_in,
   input  wire logic [15:0] status_word0_in,
   input  wire logic [15:0] status_word1_in,
   input  wire logic [7:0]  status_mfr0_in,
   input  wire logic [7:0]  status_mfr1_in,
   // control events
   input  wire logic        fault_in,
   input  wire logic        clear_peaks_in,
   input  wire logic        log_clear_in,
   // fault record read port
   input  wire logic        rd_en_in,
   input  wire logic [7:0]  rd_addr_in,
   output logic      [7:0]  rd_data_out,
   output logic      [7:0]  rd_length_out,
   // status
   output logic             fault_pending_out,
   output logic             log_valid_out
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // linear11 to a comparable fixed-point value; exponent+16 is its msb flipped
   function automatic logic signed [47:0] lin11_val(input logic [15:0] v);
      logic [4:0] sh;
      logic signed [47:0] r;
      sh = {~v[15], v[14:11]};
      r = $signed({{37{v[10]}}, v[10:0]});
      return r <<< sh;
   endfunction

   // new peak: first reading after clear loads, later only larger ones
   function automatic logic [15:0] peak_next(input logic seen, input logic is11,
                                            input logic [15:0] old, input logic [15:0] nw);
      logic bigger;
      bigger = is11 ? (lin11_val(nw) > lin11_val(old)) : (nw > old);
      return (!seen || bigger) ? nw : old;
   endfunction

   // byte of the record image, zero outside what this block builds
   function automatic logic [7:0] rec_byte(input logic [IMG_W-1:0] img, input logic [7:0] idx);
      int sh;
      sh = (IMG_BYTES - 1 - int'(idx)) * 8;
      if (idx > OFS_LAST) begin
         return 8'h00;
      end
      return img[sh +: 8];
   endfunction

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   frb_state_t       state_ff;
   frb_state_t       nxt_state;
   logic [10:0]      tick_cnt_ff;
   logic [TS_W-1:0]  time_ff;
   logic [TS_W-1:0]  fault_time_ff;
   logic [15:0]      cur_ff [0:SEL_COUNT-1];
   logic [15:0]      pk_vout0_ff;
   logic [15:0]      pk_vout1_ff;
   logic [15:0]      pk_iout0_ff;
   logic [15:0]      pk_iout1_ff;
   logic [15:0]      pk_vin_ff;
   logic [4:0]       pk_seen_ff;
   logic [IMG_W-1:0] image_ff;
   logic [IMG_W-1:0] nxt_image;
   logic             commit;

   // commit only at a sweep end while a fault waits
   assign commit = (state_ff == FRB_PENDING) && sweep_done_in;

   // ----------------------------------------------------------------
   // capture state machine
   // ----------------------------------------------------------------
   // a fault while logged is ignored: the log stays locked until cleared
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         FRB_IDLE: begin
            if (fault_in) begin
               nxt_state = FRB_PENDING;
            end
         end
         FRB_PENDING: begin
            if (sweep_done_in) begin
               nxt_state = FRB_LOGGED;
            end
         end
         FRB_LOGGED: begin
            if (log_clear_in) begin
               nxt_state = FRB_IDLE;
            end
         end
         default: begin
            nxt_state = FRB_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         state_ff <= FRB_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ----------------------------------------------------------------
   // shared-clock timestamp
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         tick_cnt_ff <= 11'h000;
         time_ff     <= 48'h0;
      end else if (tick_cnt_ff == TICK_LAST) begin
         tick_cnt_ff <= 11'h000;
         time_ff     <= time_ff + 48'h1;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 11'h001;
      end
   end

   // time caught on the fault itself, not at the later commit
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         fault_time_ff <= 48'h0;
      end else if (state_ff == FRB_IDLE && fault_in) begin
         fault_time_ff <= time_ff;
      end
   end

   // ----------------------------------------------------------------
   // working sweep and peaks
   // ----------------------------------------------------------------
   // readings of the running sweep; complete when sweep_done_in arrives
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < SEL_COUNT; i++) begin
            cur_ff[i] <= 16'h0000;
         end
      end else if (meas_valid_in && int'(meas_sel_in) < SEL_COUNT) begin
         cur_ff[meas_sel_in] <= meas_data_in;
      end
   end

   // vout is linear16 mantissa, unsigned; the rest compare as linear11
   always_ff @(posedge clock_in) begin
      if (!rst_n_in || clear_peaks_in) begin
         pk_seen_ff  <= 5'h00;
         pk_vout0_ff <= 16'h0000;
         pk_vout1_ff <= 16'h0000;
         pk_iout0_ff <= 16'h0000;
         pk_iout1_ff <= 16'h0000;
         pk_vin_ff   <= 16'h0000;
      end else if (meas_valid_in) begin
         case (meas_sel_in)
            SEL_VOUT0: begin
               pk_vout0_ff   <= peak_next(pk_seen_ff[0], 1'b0, pk_vout0_ff, meas_data_in);
               pk_seen_ff[0] <= 1'b1;
            end
            SEL_VOUT1: begin
               pk_vout1_ff   <= peak_next(pk_seen_ff[1], 1'b0, pk_vout1_ff, meas_data_in);
               pk_seen_ff[1] <= 1'b1;
            end
            SEL_IOUT0: begin
               pk_iout0_ff   <= peak_next(pk_seen_ff[2], 1'b1, pk_iout0_ff, meas_data_in);
               pk_seen_ff[2] <= 1'b1;
            end
            SEL_IOUT1: begin
               pk_iout1_ff   <= peak_next(pk_seen_ff[3], 1'b1, pk_iout1_ff, meas_data_in);
               pk_seen_ff[3] <= 1'b1;
            end
            SEL_VIN: begin
               pk_vin_ff     <= peak_next(pk_seen_ff[4], 1'b1, pk_vin_ff, meas_data_in);
               pk_seen_ff[4] <= 1'b1;
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // record image
   // ----------------------------------------------------------------
   // bytes 0-4 belong to another block and read as zero here
   assign nxt_image = {40'h0,
                       fault_time_ff[7:0], fault_time_ff[15:8], fault_time_ff[23:16],
                       fault_time_ff[31:24], fault_time_ff[39:32], fault_time_ff[47:40],
                       pk_vout0_ff, pk_vout1_ff,
                       pk_iout0_ff, pk_iout1_ff,
                       pk_vin_ff,
                       cur_ff[SEL_TEXT0], cur_ff[SEL_TEXT1], cur_ff[SEL_TDIE],
                       cur_ff[SEL_VOUT0], cur_ff[SEL_VOUT1], cur_ff[SEL_IOUT0],
                       cur_ff[SEL_IOUT1], cur_ff[SEL_VIN], cur_ff[SEL_IIN],
                       status_vout0_in, status_vout1_in, status_word0_in, status_word1_in,
                       status_mfr0_in, status_mfr1_in};

   // one wide load, so a reader never sees a mix of two captures
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         image_ff <= '0;
      end else if (commit) begin
         image_ff <= nxt_image;
      end
   end

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         rd_data_out   <= 8'h00;
         rd_length_out <= 8'h00;
      end else begin
         rd_length_out <= (nxt_state == FRB_LOGGED) ? REC_LEN : 8'h00;
         if (rd_en_in) begin
            rd_data_out <= (state_ff == FRB_LOGGED) ? rec_byte(image_ff, rd_addr_in) : 8'h00;
         end
      end
   end

   assign fault_pending_out = (state_ff == FRB_PENDING);
   assign log_valid_out     = (state_ff == FRB_LOGGED);

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);

   chk_vout_peak: assert property (commit |=> rec_byte(image_ff, OFS_VOUT_PK) == $past(pk_vout0_ff[15:8])
      && rec_byte(image_ff, 8'h0E) == $past(pk_vout1_ff[7:0])) else $error("vout peak misplaced");
   chk_peak_restart: assert property ((clear_peaks_in |=> pk_seen_ff == 5'h00)
      and (meas_valid_in && meas_sel_in == SEL_IOUT0 && !pk_seen_ff[2] && !clear_peaks_in
      |=> pk_iout0_ff == $past(meas_data_in))) else $error("peak not restarted");
   chk_iout_peak: assert property (commit |=> rec_byte(image_ff, OFS_IOUT_PK) == $past(pk_iout0_ff[15:8])
      && rec_byte(image_ff, 8'h11) == $past(pk_iout1_ff[15:8])) else $error("iout peak misplaced");
   chk_vin_peak: assert property (commit |=> rec_byte(image_ff, OFS_VIN_PK) == $past(pk_vin_ff[15:8])
      && rec_byte(image_ff, 8'h14) == $past(pk_vin_ff[7:0])) else $error("vin peak misplaced");
   chk_temps: assert property (commit |=> rec_byte(image_ff, OFS_TEMP) == $past(cur_ff[SEL_TEXT0][15:8])
      && rec_byte(image_ff, 8'h1A) == $past(cur_ff[SEL_TDIE][7:0])) else $error("temperature misplaced");
   chk_sweep_end: assert property ($rose(log_valid_out) |-> $past(sweep_done_in)
      && $past(fault_pending_out)) else $error("commit before sweep end");
   chk_event_page: assert property (commit |=> rec_byte(image_ff, OFS_EVENT) == $past(cur_ff[SEL_VOUT0][15:8])
      && rec_byte(image_ff, OFS_STATUS) == $past(status_vout0_in)
      && rec_byte(image_ff, OFS_LAST) == $past(status_mfr1_in)) else $error("event page misplaced");
   chk_length: assert property ((commit |=> rd_length_out == REC_LEN)
      and (log_valid_out && log_clear_in |=> rd_length_out == 8'h00)
      and (!log_valid_out |-> rd_length_out == 8'h00)) else $error("wrong block length");
   chk_timestamp: assert property ((state_ff == FRB_IDLE && fault_in) ##1 fault_pending_out [*2]
      |-> fault_time_ff == $past(time_ff, 2)) else $error("fault time not held");
   chk_tick_rate: assert property (tick_cnt_ff == TICK_LAST |=> time_ff == $past(time_ff) + 48'h1
      && tick_cnt_ff == 11'h000) else $error("timestamp tick wrong");
   chk_stable_log: assert property (log_valid_out && $past(log_valid_out) |-> $stable(image_ff))
      else $error("record changed while logged");

endmodule
`default_nettype wire

// ---- frb_conv_model.sv ----
`default_nettype none
module frb_conv_model (
   // clock
   input  wire logic        clock_in,
   // sweep request from the bench
   input  wire logic        start_in,
   input  wire logic [15:0] base_in,
   input  wire logic [3:0]  gap_in,
   // readings towards the builder
   output var  logic        meas_valid_out,
   output var  logic [3:0]  meas_sel_out,
   output var  logic [15:0] meas_data_out,
   output var  logic        sweep_done_out,
   output var  logic        busy_out
);
   timeunit 1ns;
   timeprecision 1ns;
   int i;
   // one process owns every output; a sweep walks all nine selectors, gap_in slows it down
   initial begin
      meas_valid_out = 1'b0;
      meas_sel_out   = 4'hF;
      meas_data_out  = 16'hA5A5;
      sweep_done_out = 1'b0;
      busy_out       = 1'b0;
      forever begin
         @(posedge clock_in);
         if (start_in) begin
            busy_out <= 1'b1;
            for (i = 0; i < 9; i++) begin
               repeat (gap_in) @(posedge clock_in);
               meas_valid_out <= 1'b1;
               meas_sel_out   <= 4'(i);
               meas_data_out  <= base_in + 16'(i) * 16'h0111;
               @(posedge clock_in);
               // back to back readings keep valid up; stale data is inverted so nothing leans on it
               if (gap_in != 4'h0 || i == 8) begin
                  meas_valid_out <= 1'b0;
                  meas_sel_out   <= ~meas_sel_out;
                  meas_data_out  <= ~meas_data_out;
               end
            end
            // done never coincides with a reading
            sweep_done_out <= 1'b1;
            @(posedge clock_in);
            sweep_done_out <= 1'b0;
            busy_out       <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`default_nettype none
`define CHK(g, e) \
   begin \
      compares++; \
      if ((g) !== (e)) begin \
         fail_count++; \
         $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); \
      end \
   end
module tb_top
   import frb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic clock_in = 1'b0, rst_n_in = 1'b0, mv, sd, busy, fault = 1'b0, clrpk = 1'b0, lclr = 1'b0, rd_en = 1'b0;
   logic cstart = 1'b0, pend, lval;
   logic [3:0] msel, cgap = 4'h0;
   logic [15:0] mdat, cbase = 16'h0000, sw0 = 16'h1234, sw1 = 16'h5678;
   logic [7:0] sv0 = 8'h11, sv1 = 8'h22, mf0 = 8'h33, mf1 = 8'h44, rd_addr = 8'h00, rd_data, rd_len, d;
   logic [15:0] cur[0:8];
   logic [15:0] pk[0:4];
   bit pk_ok = 0;
   int fail_count = 0, compares = 0, cyc = 0;
   always #50 clock_in = ~clock_in;
   always @(posedge clock_in) if (rst_n_in) cyc <= cyc + 1;
   frb_record_builder frb_record_builder_i (.clock_in(clock_in), .rst_n_in(rst_n_in), .meas_valid_in(mv),
      .meas_sel_in(msel), .meas_data_in(mdat), .sweep_done_in(sd), .status_vout0_in(sv0), .status_vout1_in(sv1),
      .status_word0_in(sw0), .status_word1_in(sw1), .status_mfr0_in(mf0), .status_mfr1_in(mf1),
      .fault_in(fault), .clear_peaks_in(clrpk), .log_clear_in(lclr), .rd_en_in(rd_en), .rd_addr_in(rd_addr),
      .rd_data_out(rd_data), .rd_length_out(rd_len), .fault_pending_out(pend), .log_valid_out(lval));
   frb_conv_model frb_conv_model_i (.clock_in(clock_in), .start_in(cstart), .base_in(cbase), .gap_in(cgap),
      .meas_valid_out(mv), .meas_sel_out(msel), .meas_data_out(mdat), .sweep_done_out(sd), .busy_out(busy));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clock_in);
      rd_en   <= 1'b1;
      rd_addr <= a;
      @(posedge clock_in);
      rd_en <= 1'b0;
      #1 v = rd_data;
   endtask
   // one-cycle strobe: bit 2 fault, bit 1 clear peaks, bit 0 log clear
   task automatic pulse(input logic [2:0] which);
      @(posedge clock_in);
      {fault, clrpk, lclr} <= which;
      @(posedge clock_in);
      {fault, clrpk, lclr} <= 3'b000;
      #1;
   endtask
   // linear11 as a signed fixed-point number, so peaks compare by value
   function automatic longint l11(input logic [15:0] v);
      longint m;
      m = longint'($signed(v[10:0]));
      return m <<< (int'($signed(v[15:11])) + 16);
   endfunction
   // expectation only, kept apart so a locked record can be checked against older data
   task automatic note_sweep(input logic [15:0] b);
      for (int i = 0; i < 9; i++) begin
         cur[i] = b + 16'(i) * 16'h0111;
         // vout peaks are unsigned linear16, current and input voltage peaks linear11
         if (i < 5 && (!pk_ok || (i < 2 ? cur[i] > pk[i] : l11(cur[i]) > l11(pk[i])))) pk[i] = cur[i];
      end
      pk_ok = 1;
   endtask
   task automatic start_sweep(input logic [15:0] b, input logic [3:0] g);
      @(posedge clock_in);
      cbase  <= b;
      cgap   <= g;
      cstart <= 1'b1;
      @(posedge clock_in);
      cstart <= 1'b0;
   endtask
   task automatic wait_sweep();
      int n;
      n = 0;
      #1;
      while (busy === 1'b1 && n < 1000) begin
         @(posedge clock_in);
         #1 n++;
      end
      `CHK(n < 1000, 1'b1)
   endtask
   function automatic logic [7:0] exp_byte(input int k);
      logic [15:0] w;
      if (k < 21) w = pk[(k - 11) / 2];
      else if (k < 27) w = cur[6 + (k - 21) / 2];
      else if (k < 39) w = cur[(k - 27) / 2];
      else if (k < 41) return (k == 39) ? sv0 : sv1;
      else if (k < 45) w = (k < 43) ? sw0 : sw1;
      else return (k == 45) ? mf0 : mf1;
      return (k % 2 == 1) ? w[15:8] : w[7:0];
   endfunction
   task automatic chk_record();
      for (int k = 11; k <= 46; k++) begin
         rd(8'(k), d);
         `CHK(d, exp_byte(k))
      end
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic s_reset_state();
      `CHK(rd_len, 8'h00)
      rd(OFS_VOUT_PK, d);
      `CHK(d, 8'h00)
   endtask
   // fault lands mid-sweep on a slow converter; the iout1 peak comes from this sweep, the other peaks from earlier sweeps
   task automatic s_capture();
      start_sweep(16'h1100, 4'h0);
      note_sweep(16'h1100);
      wait_sweep();
      start_sweep(16'h1200, 4'h0);
      note_sweep(16'h1200);
      wait_sweep();
      start_sweep(16'h1050, 4'h3);
      note_sweep(16'h1050);
      repeat (8) @(posedge clock_in);
      pulse(3'b100);
      `CHK(pend, 1'b1)
      `CHK(lval, 1'b0)
      `CHK(rd_len, 8'h00)
      wait_sweep();
      `CHK(lval, 1'b1)
      `CHK(pend, 1'b0)
      `CHK(rd_len, REC_LEN)
      chk_record();
   endtask
   // a logged record must not move with new readings or a second fault
   task automatic s_locked();
      start_sweep(16'h1300, 4'h0);
      pulse(3'b100);
      @(posedge clock_in);
      sv0 <= 8'h99;
      wait_sweep();
      `CHK(pend, 1'b0)
      @(posedge clock_in);
      sv0 <= 8'h11;
      chk_record();
      pulse(3'b001);
      #100;
      `CHK(rd_len, 8'h00)
      `CHK(lval, 1'b0)
      rd(OFS_EVENT, d);
      `CHK(d, 8'h00)
   endtask
   // restart peak tracking with a smaller sweep and check the timestamp bytes
   task automatic s_clear_peaks();
      pulse(3'b010);
      pk_ok = 0;
      @(posedge clock_in);
      sw0 <= 16'hBEEF;
      mf1 <= 8'h5A;
      while (cyc < 5000) @(posedge clock_in);
      pulse(3'b100);
      start_sweep(16'h1080, 4'h1);
      note_sweep(16'h1080);
      wait_sweep();
      chk_record();
      for (int k = 5; k <= 10; k++) begin
         rd(8'(k), d);
         `CHK(d, (k == 5) ? 8'h02 : 8'h00)
      end
      rd(8'h2F, d);
      `CHK(d, 8'h00)
   endtask
   // ----------------------------------------------------------------
   // run control
   // ----------------------------------------------------------------
   task automatic close_out();
      $display("mismatches %0d compares %0d", fail_count, compares);
      if (fail_count == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // the tests need about 5100 cycles; 20000 leaves ample margin
   initial begin
      #2000000;
      fail_count++;
      $display("wrong value at %0t: watchdog expired", $time);
      close_out();
   end
   initial begin
      repeat (3) @(posedge clock_in);
      rst_n_in <= 1'b1;
      #1;
      s_reset_state();
      s_capture();
      s_locked();
      s_clear_peaks();
      close_out();
   end
endmodule
`default_nettype wire
